// ---- rtl/lao_defs.svh ----
// Offsets, field positions, reset values and counts of the lane alarm and offset trim bank
`ifndef LAO_DEFS_SVH
`define LAO_DEFS_SVH

// Register byte addresses on the control port
`define LAO_ADDR_ALARM_STATUS   12'h2C1
`define LAO_ADDR_ALARM_MASK     12'h2C2
`define LAO_ADDR_LANE_FAULT     12'h2C4
`define LAO_ADDR_CORE0_TRIM     12'h330
`define LAO_ADDR_CORE1_TRIM     12'h332
`define LAO_ADDR_CORE2A_TRIM    12'h334
`define LAO_ADDR_CORE2B_TRIM    12'h336

// Field positions
`define LAO_SUMMARY_FIFO_BIT    5
`define LAO_TRIM_MSB            11
`define LAO_TRIM_WIDTH          12
`define LAO_LANES               8

// Reset values
`define LAO_LANE_FAULT_RST      8'hFF
`define LAO_SUMMARY_FAULT_RST   1'h1
`define LAO_SUMMARY_MASK_RST    1'h1
`define LAO_TRIM_RST            16'h0000

// Number of trim words fetched from fuse storage after reset
`define LAO_TRIM_COUNT          4
`define LAO_TRIM_LAST_IDX       2'h3

`endif

// ---- rtl/lao_pkg.sv ----
// Types shared by the lane alarm and offset trim bank
package lao_pkg;

  // Fuse load sequence, Gray coded along idle -> fetch -> done
  typedef enum logic [1:0] {
    LAO_FL_IDLE  = 2'h0,
    LAO_FL_FETCH = 2'h1,
    LAO_FL_DONE  = 2'h3
  } lao_fuse_state_t;

  // Index of a trim word
  typedef logic [1:0] lao_trim_idx_t;

endpackage

// ---- rtl/lao_regs.sv ----
// Lane fault flags, summary fifo alarm and offset trim registers
`timescale 1ns/10ps
`default_nettype none
`include "lao_defs.svh"

// Functional notes
// RULE1: Lane buffer fault sets its lane flag
// RULE2: Writing one clears that lane flag only
// RULE3: Persisting fault sets the flag again immediately
// RULE4: Clearing summary fault bit clears all lanes
// RULE5: Lane flags reset to all ones
// RULE6: Twelve-bit unsigned trim applied to its core
// RULE7: Software writes zero to trim reserved bits
// RULE8: No trim access during offset calibration
// RULE9: Foreground-only offset cal: wait for done
// RULE10: Both background offset modes: never access trims
// RULE11: Spare cores offset-calibrated in foreground step
// RULE12: Otherwise trims accessible without waiting
// RULE13: Core two keeps separate pair A/B trims
// RULE14: Trim defaults loaded from fuses after reset
// RULE15: Active lane fault sets summary fault bit
// RULE16: Masked summary fault leaves alarm unaffected
// RULE17: Lane flags stay set until software clears
module lao_regs
  import lao_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register access port behind the serial control interface
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [11:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  // Lane fifo fault levels from the serializer domain
  input  wire logic [7:0]  lane_fifo_err,
  input  wire logic [7:0]  lane_active,
  // Calibration configuration and status
  input  wire logic        foreground_offset_cal_enable,
  input  wire logic        background_cal_enable,
  input  wire logic        background_offset_cal_enable,
  input  wire logic        foreground_cal_done,
  input  wire logic        offset_cal_running,
  // Fuse storage read port
  output logic             fuse_rd_en,
  output logic      [1:0]  fuse_rd_idx,
  input  wire logic        fuse_rd_valid,
  input  wire logic [11:0] fuse_rd_data,
  // Core side
  input  wire logic        core2_sample_input_b,
  output logic      [11:0] core0_offset,
  output logic      [11:0] core1_offset,
  output logic      [11:0] core2_offset,
  output logic             spare_core_fg_offset_cal,
  output logic             trim_access_ok,
  output logic             trim_load_done,
  output logic             summary_alarm
);

  logic [7:0]      lane_err_sync;          // Filtered lane faults
  logic [7:0]      lane_fault_flags_ff;    // Sticky lane flags
  logic [7:0]      nxt_lane_fault_flags;
  logic            summary_fault_ff;       // Sticky summary fifo fault
  logic            nxt_summary_fault;
  logic            summary_mask_ff;        // Summary fault mask
  logic [15:0]     trim_ff [`LAO_TRIM_COUNT]; // Trim words, index order 0,1,2A,2B
  lao_fuse_state_t fuse_state_ff;          // Fuse load sequence
  lao_trim_idx_t   fuse_idx_ff;            // Word being fetched
  logic [15:0]     rdata_ff;               // Read data holding register
  logic            rvalid_ff;              // Read answer strobe
  logic            wr_lane;                // Write hits lane flags
  logic            wr_status;              // Write hits alarm status
  logic            wr_trim;                // Write hits a trim word
  lao_trim_idx_t   trim_sel;               // Trim word decoded from address
  logic            clr_all;                // Summary clear also clears lanes
  logic            any_fault;              // Fault on any active lane

  // Fault levels cross from the lane clock
  lao_sync #(
    .WIDTH (`LAO_LANES)
  ) u_lane_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (lane_fifo_err),
    .sync_out (lane_err_sync)
  );

  // Address decode
  always_comb
  begin
    wr_lane   = reg_wr && (reg_addr == `LAO_ADDR_LANE_FAULT);
    wr_status = reg_wr && (reg_addr == `LAO_ADDR_ALARM_STATUS);
    wr_trim   = 1'b0;
    trim_sel  = 2'h0;
    case (reg_addr)
      `LAO_ADDR_CORE0_TRIM:
      begin
        wr_trim  = reg_wr;
        trim_sel = 2'h0;
      end
      `LAO_ADDR_CORE1_TRIM:
      begin
        wr_trim  = reg_wr;
        trim_sel = 2'h1;
      end
      `LAO_ADDR_CORE2A_TRIM:
      begin
        wr_trim  = reg_wr;
        trim_sel = 2'h2;
      end
      `LAO_ADDR_CORE2B_TRIM:
      begin
        wr_trim  = reg_wr;
        trim_sel = 2'h3;
      end
      default:
      begin
        wr_trim  = 1'b0;
        trim_sel = 2'h0;
      end
    endcase
  end

  // Next values of the sticky flags; a set in the clear cycle wins
  always_comb
  begin
    clr_all   = wr_status && reg_wdata[`LAO_SUMMARY_FIFO_BIT];                   // RULE4
    any_fault = |(lane_err_sync & lane_active);
    nxt_lane_fault_flags = lane_fault_flags_ff;
    if (wr_lane)
    begin
      nxt_lane_fault_flags = nxt_lane_fault_flags & ~reg_wdata[7:0];             // RULE2
    end
    if (clr_all)
    begin
      nxt_lane_fault_flags = 8'h00;                                              // RULE4
    end
    nxt_lane_fault_flags = nxt_lane_fault_flags | lane_err_sync;                 // RULE1 RULE3 RULE17
    nxt_summary_fault = (summary_fault_ff & ~clr_all) | any_fault;               // RULE15
  end

  // Lane flags and summary fault, both sticky
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lane_fault_flags_ff <= `LAO_LANE_FAULT_RST;                                 // RULE5
      summary_fault_ff    <= `LAO_SUMMARY_FAULT_RST;
    end
    else
    begin
      lane_fault_flags_ff <= nxt_lane_fault_flags;
      summary_fault_ff    <= nxt_summary_fault;
    end
  end

  // Summary mask, plain read/write
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      summary_mask_ff <= `LAO_SUMMARY_MASK_RST;
    end
    else if (reg_wr && (reg_addr == `LAO_ADDR_ALARM_MASK))
    begin
      summary_mask_ff <= reg_wdata[`LAO_SUMMARY_FIFO_BIT];
    end
  end

  // Combined alarm sees only an unmasked summary fault
  assign summary_alarm = summary_fault_ff & ~summary_mask_ff;                     // RULE16

  // Fuse load sequence; runs once after reset release
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fuse_state_ff <= LAO_FL_IDLE;
      fuse_idx_ff   <= 2'h0;
    end
    else
    begin
      case (fuse_state_ff)
        LAO_FL_IDLE:
        begin
          fuse_state_ff <= LAO_FL_FETCH;
        end
        LAO_FL_FETCH:
        begin
          if (fuse_rd_valid)
          begin
            fuse_idx_ff <= fuse_idx_ff + 2'h1;
            if (fuse_idx_ff == `LAO_TRIM_LAST_IDX)
            begin
              fuse_state_ff <= LAO_FL_DONE;
            end
          end
        end
        LAO_FL_DONE:
        begin
          fuse_state_ff <= LAO_FL_DONE;
        end
        default:
        begin
          fuse_state_ff <= LAO_FL_IDLE;
        end
      endcase
    end
  end

  // Request held until the fuse answers
  assign fuse_rd_en     = (fuse_state_ff == LAO_FL_FETCH);
  assign fuse_rd_idx    = fuse_idx_ff;
  assign trim_load_done = (fuse_state_ff == LAO_FL_DONE);

  // Trim words: fuse defaults first, software writes after the load
  // Writes during the load are dropped so a fuse word cannot overwrite them
  genvar gt;
  generate
    for (gt = 0; gt < `LAO_TRIM_COUNT; gt++)
    begin : g_trim
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          trim_ff[gt] <= `LAO_TRIM_RST;
        end
        else if (fuse_rd_en && fuse_rd_valid && (fuse_idx_ff == 2'(gt)))
        begin
          trim_ff[gt] <= {4'h0, fuse_rd_data};                                    // RULE14
        end
        else if (trim_load_done && wr_trim && (trim_sel == 2'(gt)))
        begin
          trim_ff[gt] <= reg_wdata;                                               // RULE7
        end
      end
    end
  endgenerate

  // Low twelve bits drive the cores; pair select picks core two trim
  assign core0_offset = trim_ff[0][`LAO_TRIM_MSB:0];                              // RULE6
  assign core1_offset = trim_ff[1][`LAO_TRIM_MSB:0];                              // RULE6
  assign core2_offset = core2_sample_input_b ? trim_ff[3][`LAO_TRIM_MSB:0]
                                             : trim_ff[2][`LAO_TRIM_MSB:0];       // RULE13

  // Spare cores join the foreground offset step in this setting
  assign spare_core_fg_offset_cal = foreground_offset_cal_enable & background_cal_enable
                                    & ~background_offset_cal_enable;              // RULE11

  // Advisory status for software; the device does not block access itself
  always_comb
  begin
    if (offset_cal_running)
    begin
      trim_access_ok = 1'b0;                                                      // RULE8
    end
    else if (background_cal_enable && background_offset_cal_enable)
    begin
      trim_access_ok = 1'b0;                                                      // RULE10
    end
    else if (foreground_offset_cal_enable)
    begin
      trim_access_ok = foreground_cal_done;                                       // RULE9
    end
    else
    begin
      trim_access_ok = 1'b1;                                                      // RULE12
    end
  end

  // Registered read answer; unmapped addresses read zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= reg_rd;
      if (reg_rd)
      begin
        case (reg_addr)
          `LAO_ADDR_LANE_FAULT:   rdata_ff <= {8'h00, lane_fault_flags_ff};
          `LAO_ADDR_ALARM_STATUS: rdata_ff <= {10'h000, summary_fault_ff, 5'h00};
          `LAO_ADDR_ALARM_MASK:   rdata_ff <= {10'h000, summary_mask_ff, 5'h00};
          `LAO_ADDR_CORE0_TRIM:   rdata_ff <= trim_ff[0];
          `LAO_ADDR_CORE1_TRIM:   rdata_ff <= trim_ff[1];
          `LAO_ADDR_CORE2A_TRIM:  rdata_ff <= trim_ff[2];
          `LAO_ADDR_CORE2B_TRIM:  rdata_ff <= trim_ff[3];
          default:                rdata_ff <= 16'h0000;
        endcase
      end
    end
  end

  assign reg_rdata  = rdata_ff;
  assign reg_rvalid = rvalid_ff;

endmodule

`default_nettype wire

// ---- rtl/lao_sync.sv ----
// Three-flop synchroniser with agreement filter, one per bit
`timescale 1ns/10ps
`default_nettype none

module lao_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  genvar gi;

  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      logic meta_ff;    // First stage, read only by the second
      logic mid_ff;     // Second stage
      logic last_ff;    // Third stage
      logic level_ff;   // Accepted level

      // Shift chain; a change counts once second and third agree
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          meta_ff  <= 1'h0;
          mid_ff   <= 1'h0;
          last_ff  <= 1'h0;
          level_ff <= 1'h0;
        end
        else
        begin
          meta_ff <= async_in[gi];
          mid_ff  <= meta_ff;
          last_ff <= mid_ff;
          if (mid_ff == last_ff)
          begin
            level_ff <= last_ff;
          end
        end
      end

      assign sync_out[gi] = level_ff;
    end
  endgenerate

endmodule

`default_nettype wire

// ---- test/lao_regs_monitor.sv ----
// Port checker for the lane alarm and offset trim bank
`timescale 1ns/10ps
`default_nettype none
`include "lao_defs.svh"
module lao_regs_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_rvalid,
  input wire logic        foreground_offset_cal_enable,
  input wire logic        background_cal_enable,
  input wire logic        background_offset_cal_enable,
  input wire logic        fuse_rd_en,
  input wire logic [1:0]  fuse_rd_idx,
  input wire logic        fuse_rd_valid,
  input wire logic [11:0] fuse_rd_data,
  input wire logic        core2_sample_input_b,
  input wire logic [11:0] core0_offset,
  input wire logic [11:0] core2_offset,
  input wire logic        spare_core_fg_offset_cal,
  input wire logic        trim_load_done,
  input wire logic        summary_alarm
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Decoded trim writes
  logic wr_c0;
  logic wr_2a;
  logic wr_2b;
  assign wr_c0 = reg_wr && reg_addr == `LAO_ADDR_CORE0_TRIM;
  assign wr_2a = reg_wr && reg_addr == `LAO_ADDR_CORE2A_TRIM && trim_load_done;
  assign wr_2b = reg_wr && reg_addr == `LAO_ADDR_CORE2B_TRIM && trim_load_done;
  AST_RD_ANSWER: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  AST_RD_QUIET: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read answer");
  AST_TRIM_APPLY: assert property (wr_c0 && trim_load_done |=>
    core0_offset == $past(reg_wdata[11:0])) else $error("core0 trim not applied");
  AST_PAIR_A: assert property (wr_2a && !core2_sample_input_b ##1 !core2_sample_input_b
    |-> core2_offset == $past(reg_wdata[11:0])) else $error("pair A trim wrong");
  AST_PAIR_B: assert property (wr_2b && core2_sample_input_b ##1 core2_sample_input_b
    |-> core2_offset == $past(reg_wdata[11:0])) else $error("pair B trim wrong");
  AST_EARLY_DROP: assert property (wr_c0 && !trim_load_done && !fuse_rd_valid
    |=> $stable(core0_offset)) else $error("trim write taken before load");
  AST_FUSE_STORE: assert property (fuse_rd_en && fuse_rd_valid && fuse_rd_idx == 2'h0
    |=> core0_offset == $past(fuse_rd_data)) else $error("fuse word not stored");
  AST_FUSE_HOLD: assert property (fuse_rd_en && !fuse_rd_valid
    |=> fuse_rd_en && $stable(fuse_rd_idx)) else $error("fuse request dropped");
  AST_LOAD_START: assert property ($rose(rst_n) |-> !trim_load_done ##1 fuse_rd_en)
    else $error("fuse load not started");
  AST_SPARE: assert property (spare_core_fg_offset_cal == (foreground_offset_cal_enable
    && background_cal_enable && !background_offset_cal_enable)) else $error("spare cal wrong");
  AST_MASK: assert property (reg_wr && reg_addr == `LAO_ADDR_ALARM_MASK && reg_wdata[5]
    |=> !summary_alarm) else $error("masked alarm seen");
  // Main scenarios reached
  COV_FUSE: cover property (fuse_rd_en && fuse_rd_valid && fuse_rd_idx == 2'h3);
  COV_ALARM: cover property (summary_alarm);
  COV_SPARE: cover property (spare_core_fg_offset_cal);
endmodule

bind lao_regs lao_regs_monitor u_mon (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid),
  .foreground_offset_cal_enable(foreground_offset_cal_enable),
  .background_cal_enable(background_cal_enable),
  .background_offset_cal_enable(background_offset_cal_enable), .fuse_rd_en(fuse_rd_en),
  .fuse_rd_idx(fuse_rd_idx), .fuse_rd_valid(fuse_rd_valid), .fuse_rd_data(fuse_rd_data),
  .core2_sample_input_b(core2_sample_input_b), .core0_offset(core0_offset),
  .core2_offset(core2_offset), .spare_core_fg_offset_cal(spare_core_fg_offset_cal),
  .trim_load_done(trim_load_done), .summary_alarm(summary_alarm));
`default_nettype wire

// ---- test/lao_regs_test.sv ----
// Self-checking bench of the lane alarm and offset trim bank
`timescale 1ns/10ps
`default_nettype none
`include "lao_defs.svh"
module lao_regs_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rw = 1'b0;
  logic rr = 1'b0;
  logic [11:0] ra = 12'h000;
  logic [15:0] wd = 16'h0000;
  logic [15:0] rdat;
  logic rv;
  logic [7:0] err = 8'h00;
  logic [7:0] act = 8'hFF;
  logic [2:0] cal = 3'h0;
  logic fdone = 1'b0;
  logic run = 1'b0;         // Offset calibration in progress
  logic ok_m;               // Model of the access advisory
  logic fen;
  logic [1:0] fidx;
  logic fval = 1'b0;
  logic [11:0] fdat = 12'h000;
  logic selb = 1'b0;
  logic [11:0] o0, o1, o2;
  logic spare, ok, ldone, alarm;
  logic [15:0] trim_m [4];  // Model of the four trim words
  logic [7:0] bit_m;        // Model of one lane bit
  int err_total = 0;
  int checks_done = 0;
  lao_regs u_dut (.clk(clk), .rst_n(rst_n), .reg_wr(rw), .reg_rd(rr), .reg_addr(ra),
    .reg_wdata(wd), .reg_rdata(rdat), .reg_rvalid(rv), .lane_fifo_err(err),
    .lane_active(act), .foreground_offset_cal_enable(cal[2]), .background_cal_enable(cal[1]),
    .background_offset_cal_enable(cal[0]), .foreground_cal_done(fdone),
    .offset_cal_running(run), .fuse_rd_en(fen), .fuse_rd_idx(fidx), .fuse_rd_valid(fval),
    .fuse_rd_data(fdat), .core2_sample_input_b(selb), .core0_offset(o0), .core1_offset(o1),
    .core2_offset(o2), .spare_core_fg_offset_cal(spare), .trim_access_ok(ok),
    .trim_load_done(ldone), .summary_alarm(alarm));
  // Free-running clock
  always #4 clk = ~clk;
  // Fuse storage answering after a random delay
  always @(negedge clk)
  begin
    fval = (fen === 1'b1) && ($urandom_range(1, 0) == 1);
    if (fval)
    begin
      fdat = 12'($urandom);
      trim_m[fidx] = {4'h0, fdat};
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge clk);
    rw = 1'b1;
    ra = a;
    wd = d;
    @(negedge clk);
    rw = 1'b0;
  endtask
  // Answer must stand in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [15:0] exp, input string what);
    @(negedge clk);
    rr = 1'b1;
    ra = a;
    @(negedge clk);
    rr = 1'b0;
    chk(what, exp, (rv === 1'b1) ? rdat : 16'hBAD0);
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial
  begin
    #100000;
    err_total++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'h247EB4A8));
    repeat (8) @(negedge clk);
    // Trim write in the first cycle out of reset, before the fuse load: dropped
    rst_n = 1'b1;
    rw = 1'b1;
    ra = `LAO_ADDR_CORE0_TRIM;
    wd = 16'h0ABC;
    @(negedge clk);
    rw = 1'b0;
    rd(`LAO_ADDR_LANE_FAULT, 16'h00FF, "lane_flags");
    rd(`LAO_ADDR_ALARM_STATUS, 16'h0020, "status");
    rd(12'h2C3, 16'h0000, "unmapped");
    for (int i = 0; i < 200 && ldone !== 1'b1; i++) @(negedge clk);
    chk("load_done", 16'h0001, {15'h0, ldone});
    chk("core0", trim_m[0], {4'h0, o0});
    chk("core1", trim_m[1], {4'h0, o1});
    chk("core2a", trim_m[2], {4'h0, o2});
    // Calibration idle and all background offset modes off: trims free to touch
    for (int i = 0; i < 4; i++)
    begin
      trim_m[i] = 16'($urandom) & 16'h0FFF;
      wr(`LAO_ADDR_CORE0_TRIM + 12'(2 * i), trim_m[i]);
    end
    for (int i = 0; i < 4; i++)
      rd(`LAO_ADDR_CORE0_TRIM + 12'(2 * i), trim_m[i], "trim");
    chk("core0", trim_m[0], {4'h0, o0});
    chk("core1", trim_m[1], {4'h0, o1});
    chk("core2a", trim_m[2], {4'h0, o2});
    selb = 1'b1;
    @(negedge clk);
    chk("core2b", trim_m[3], {4'h0, o2});
    // Pair B word rewritten while pair B is in use
    trim_m[3] = 16'($urandom) & 16'h0FFF;
    wr(`LAO_ADDR_CORE2B_TRIM, trim_m[3]);
    chk("core2b", trim_m[3], {4'h0, o2});
    wr(`LAO_ADDR_ALARM_STATUS, 16'h0020);
    rd(`LAO_ADDR_LANE_FAULT, 16'h0000, "lane_flags");
    bit_m = 8'h01 << $urandom_range(7, 0);
    err = bit_m;
    repeat (8) @(negedge clk);
    err = 8'h00;
    repeat (8) @(negedge clk);
    rd(`LAO_ADDR_LANE_FAULT, {8'h00, bit_m}, "lane_flags");
    rd(`LAO_ADDR_ALARM_STATUS, 16'h0020, "status");
    wr(`LAO_ADDR_ALARM_MASK, 16'h0000);
    chk("alarm", 16'h0001, {15'h0, alarm});
    wr(`LAO_ADDR_ALARM_MASK, 16'h0020);
    chk("alarm", 16'h0000, {15'h0, alarm});
    wr(`LAO_ADDR_LANE_FAULT, {8'h00, ~bit_m});
    rd(`LAO_ADDR_LANE_FAULT, {8'h00, bit_m}, "lane_flags");
    wr(`LAO_ADDR_LANE_FAULT, {8'h00, bit_m});
    rd(`LAO_ADDR_LANE_FAULT, 16'h0000, "lane_flags");
    // Fault held on an inactive lane: flag re-arms, summary stays low
    act = 8'h00;
    wr(`LAO_ADDR_ALARM_STATUS, 16'h0020);
    err = 8'h80;
    repeat (8) @(negedge clk);
    wr(`LAO_ADDR_LANE_FAULT, 16'h0080);
    rd(`LAO_ADDR_LANE_FAULT, 16'h0080, "lane_flags");
    rd(`LAO_ADDR_ALARM_STATUS, 16'h0000, "status");
    // Every calibration setting, done flag and running state
    for (int i = 0; i < 32; i++)
    begin
      @(negedge clk);
      cal = i[2:0];
      fdone = i[3];
      run = i[4];
      #1;
      ok_m = !i[4] && !(i[1] && i[0]) && (!i[2] || i[3]);
      chk("spare_cal", {15'h0, i[2:0] == 3'h6}, {15'h0, spare});
      chk("access_ok", {15'h0, ok_m}, {15'h0, ok});
    end
    // Reset again mid-run: flags back to all ones, fuse load restarts
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    rd(`LAO_ADDR_LANE_FAULT, 16'h00FF, "lane_flags");
    chk("load_done", 16'h0000, {15'h0, ldone});
    end_of_test();
  end
endmodule
`default_nettype wire
